// ==== common/ttc_pkg.sv ====
// shared constants and types for the triple timer, capture and interrupt block
package ttc_pkg;

	// internal state clock: one state per 400 ns at a 10 ns system clock
	localparam int STATE_TIME_NS = 400;
	localparam int CLK_PERIOD_NS = 10;
	localparam int STATE_CYCLES  = (STATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DIV_W         = 6;

	localparam int NUM_TMR = 3;
	localparam int NUM_LVL = 5;
	localparam int CNT_W   = 8;
	localparam int VEC_W   = 16;

	// register byte offsets
	localparam logic [11:0] OFS_CTRL    = 12'h000;
	localparam logic [11:0] OFS_RELOAD  = 12'h004;
	localparam logic [11:0] OFS_COUNT   = 12'h010;
	localparam logic [11:0] OFS_CAPTURE = 12'h01c;
	localparam logic [11:0] OFS_STATUS  = 12'h020;
	localparam logic [11:0] OFS_CLEAR   = 12'h024;
	localparam logic [11:0] OFS_ENABLE  = 12'h028;
	localparam logic [11:0] OFS_VECTOR  = 12'h030;
	localparam logic [11:0] OFS_STEP    = 12'h004;

	// field positions
	localparam int PRE_LSB  = 8;
	localparam int LVL_LSB  = 1;

	// values after reset
	localparam logic [7:0]       CTRL_RST   = 8'h00;
	localparam logic [CNT_W-1:0] RELOAD_RST = 8'hff;
	localparam logic [4:0]       ENABLE_RST = 5'h00;
	localparam logic [VEC_W-1:0] VECTOR_RST = 16'h0000;

	typedef struct packed {
		logic       gie;
		logic       t3_baud;
		logic       cascade;
		logic       t2_ext;
		logic       t1_ext;
		logic [2:0] run;
	} ttc_ctrl_type;

	typedef struct packed {
		logic        write;
		logic [11:0] addr;
	} ttc_addr_phase_type;

	typedef struct packed {
		logic             req;
		logic [2:0]       level;
		logic [VEC_W-1:0] vector;
	} ttc_irq_type;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_DATA = 2'b01
	} ttc_bus_state_type;

endpackage : ttc_pkg

// ==== design/ttc_top.sv ====
// triple countdown timer with capture latch and prioritized vectored interrupts
//
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/10ps
//
// Behaviour
// - each of three timers has its own run bit, independent of the others
// - timers one and two: 8-bit counter behind a 5-bit prescaler
// - timers one and two clock from state clock or external event, selectable
// - timers one and two chain into one 26-bit timer
// - timer three: 8-bit counter behind a 2-bit prescaler
// - timer three is interval timer or serial bit-rate clock
// - counters count down and reload from their latch past zero
// - falling edge on capture pin latches timer one count
// - six levels; level 0 is reset and cannot be masked
// - levels one and three react to falling pin edges only
// - timer one level two, serial and timer three four, timer two five
// - each level supplies its own software-written vector
// - global enable gates all; each level has its own enable
// - level one pin wins over every other maskable source
// - timer one external clock comes from event input one
// - timer two external clock comes from event input two
//
module ttc_top
	import ttc_pkg::*;
#(
	parameter int PRE_W  = 5,
	parameter int PRE3_W = 2
) (
	// clock and reset
	input  wire logic               sys_clk,
	input  wire logic               reset,
	// ahb-lite slave
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output      logic [31:0]        hrdata,
	output      logic               hreadyout,
	output      logic               hresp,
	// external pins and serial events
	input  wire logic               ext_irq_high_pin,
	input  wire logic               ext_irq_capture_pin,
	input  wire logic               event_count_in_one,
	input  wire logic               event_count_in_two,
	input  wire logic               serial_rx_event,
	input  wire logic               serial_tx_event,
	// outputs to cpu and serial port
	output      ttc_irq_type        irq,
	output      logic               baud_tick
);

	if (PRE_W < 1 || PRE_W > 8 || PRE3_W < 1 || PRE3_W > PRE_W) begin : g_check
		$error("ttc_top: prescaler widths out of range");
	end

	////////////////////////////////////////////////////////////////////////////////
	// state clock enable

	logic [DIV_W-1:0] div_cnt;
	logic             state_en;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			div_cnt  <= '0;
			state_en <= 1'b0;
		end else if (div_cnt == DIV_W'(STATE_CYCLES - 1)) begin
			div_cnt  <= '0;
			state_en <= 1'b1;
		end else begin
			div_cnt  <= div_cnt + 1'b1;
			state_en <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin edges: {event two, event one, capture, high}

	logic [3:0] pin_now;
	logic [3:0] pin_prev;
	logic [3:0] pin_fall;

	assign pin_now  = {event_count_in_two, event_count_in_one,
		ext_irq_capture_pin, ext_irq_high_pin};
	assign pin_fall = pin_prev & ~pin_now;

	// idle-high reset value, so a pin held low at release counts as a falling edge
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pin_prev <= 4'hf;
		end else begin
			pin_prev <= pin_now;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus slave: one wait state, so a write always lands before a later read

	ttc_bus_state_type  bus_state;
	ttc_addr_phase_type ap;
	ttc_ctrl_type       ctrl;
	logic               wr;
	logic [31:0]        next_rdata;

	assign wr = (bus_state == BUS_DATA) && ap.write;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			bus_state <= BUS_IDLE;
			ap        <= '0;
			hreadyout <= 1'b1;
			hrdata    <= 32'h0000_0000;
			hresp     <= 1'b0;
		end else begin
			case (bus_state)
				BUS_IDLE: begin
					if (hsel && htrans[1] && hready) begin
						ap        <= '{write: hwrite, addr: haddr[11:0]};
						bus_state <= BUS_DATA;
						hreadyout <= 1'b0;
					end
				end
				BUS_DATA: begin
					hrdata    <= ap.write ? 32'h0000_0000 : next_rdata;
					hreadyout <= 1'b1;
					bus_state <= BUS_IDLE;
				end
				default: begin
					bus_state <= BUS_IDLE;
					hreadyout <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ctrl <= CTRL_RST;
		end else if (wr && ap.addr == OFS_CTRL) begin
			ctrl <= hwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// timers

	logic [CNT_W-1:0] reload    [NUM_TMR];
	logic [PRE_W-1:0] pre_load  [NUM_TMR];
	logic [CNT_W-1:0] count     [NUM_TMR];
	logic [PRE_W-1:0] pre_count [NUM_TMR];
	logic [NUM_TMR-1:0] tick;
	logic [NUM_TMR-1:0] underflow;

	assign tick[0] = ctrl.run[0] && (ctrl.t1_ext ? pin_fall[2] : state_en);
	// cascade stretches timer one's 13 bits by timer two's 13 bits
	assign tick[1] = ctrl.run[1] && (ctrl.cascade ? underflow[0] :
		(ctrl.t2_ext ? pin_fall[3] : state_en));
	assign tick[2] = ctrl.run[2] && state_en;

	for (genvar i = 0; i < NUM_TMR; i++) begin : g_tmr
		localparam logic [11:0] RELOAD_OFS = OFS_RELOAD + 12'(4 * i);

		assign underflow[i] = tick[i] && pre_count[i] == '0 && count[i] == '0;

		always_ff @(posedge sys_clk) begin
			if (reset) begin
				reload[i]   <= RELOAD_RST;
				pre_load[i] <= '0;
			end else if (wr && ap.addr == RELOAD_OFS) begin
				reload[i]   <= hwdata[CNT_W-1:0];
				// timer three keeps only its narrow prescaler
				pre_load[i] <= (i == 2) ? PRE_W'(hwdata[PRE_LSB+PRE3_W-1:PRE_LSB])
					: hwdata[PRE_LSB+PRE_W-1:PRE_LSB];
			end
		end

		// a stopped timer tracks its latch, so starting it begins a full period
		always_ff @(posedge sys_clk) begin
			if (reset) begin
				count[i]     <= RELOAD_RST;
				pre_count[i] <= '0;
			end else if (!ctrl.run[i]) begin
				count[i]     <= reload[i];
				pre_count[i] <= pre_load[i];
			end else if (tick[i]) begin
				if (pre_count[i] == '0) begin
					pre_count[i] <= pre_load[i];
					count[i]     <= (count[i] == '0) ? reload[i] : count[i] - 1'b1;
				end else begin
					pre_count[i] <= pre_count[i] - 1'b1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			baud_tick <= 1'b0;
		end else begin
			baud_tick <= ctrl.t3_baud && underflow[2];
		end
	end

	logic [CNT_W-1:0] capture;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			capture <= '0;
		end else if (pin_fall[1]) begin
			capture <= count[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupt status, enable, vectors and priority

	logic [NUM_LVL:1] event_set;
	logic [NUM_LVL:1] status;
	logic [NUM_LVL:1] enable;
	logic [NUM_LVL:1] pending;
	logic [VEC_W-1:0] vec [NUM_LVL];
	logic [2:0]       next_level;

	assign event_set[1] = pin_fall[0];
	assign event_set[2] = underflow[0];
	assign event_set[3] = pin_fall[1];
	// in baud mode timer three only paces the serial port
	assign event_set[4] = serial_rx_event || serial_tx_event ||
		(underflow[2] && !ctrl.t3_baud);
	assign event_set[5] = underflow[1];

	// a new event wins over a clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			status <= '0;
		end else if (wr && ap.addr == OFS_CLEAR) begin
			status <= (status & ~hwdata[NUM_LVL:LVL_LSB]) | event_set;
		end else begin
			status <= status | event_set;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			enable <= ENABLE_RST;
		end else if (wr && ap.addr == OFS_ENABLE) begin
			enable <= hwdata[NUM_LVL:LVL_LSB];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			for (int k = 0; k < NUM_LVL; k++) begin
				vec[k] <= VECTOR_RST;
			end
		end else begin
			for (int k = 0; k < NUM_LVL; k++) begin
				if (wr && ap.addr == OFS_VECTOR + 12'(4 * k)) begin
					vec[k] <= hwdata[VEC_W-1:0];
				end
			end
		end
	end

	assign pending = status & enable & {NUM_LVL{ctrl.gie}};

	always_comb begin
		next_level = 3'h0;
		for (int k = NUM_LVL; k >= 1; k--) begin
			if (pending[k]) begin
				next_level = 3'(k);
			end
		end
	end

	// reset is level 0: it clears every request and needs no enable
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			irq <= '0;
		end else begin
			irq.req   <= |pending;
			irq.level <= next_level;
			irq.vector <= (next_level == 3'h0) ? VECTOR_RST : vec[next_level - 3'h1];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read mux; unmapped offsets read zero

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (ap.addr)
			OFS_CTRL:    next_rdata[7:0] = ctrl;
			OFS_CAPTURE: next_rdata[CNT_W-1:0] = capture;
			OFS_STATUS:  next_rdata[NUM_LVL:LVL_LSB] = status;
			OFS_ENABLE:  next_rdata[NUM_LVL:LVL_LSB] = enable;
			default:     next_rdata = 32'h0000_0000;
		endcase
		for (int k = 0; k < NUM_TMR; k++) begin
			if (ap.addr == OFS_RELOAD + 12'(4 * k)) begin
				next_rdata = 32'({pre_load[k], reload[k]});
			end
			if (ap.addr == OFS_COUNT + 12'(4 * k)) begin
				next_rdata = 32'({pre_count[k], count[k]});
			end
		end
		for (int k = 0; k < NUM_LVL; k++) begin
			if (ap.addr == OFS_VECTOR + 12'(4 * k)) begin
				next_rdata = 32'(vec[k]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// assertions and covers

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	bus_wait_state_a: assert property ((bus_state == BUS_IDLE && hsel && htrans[1] && hready)
		|=> !hreadyout ##1 hreadyout) else $error("bus answer not one wait state");

	stopped_tracks_a: assert property (!ctrl.run[0] |=> count[0] == $past(reload[0]))
		else $error("stopped timer does not follow its latch");

	prescale_hold_a: assert property ((tick[0] && pre_count[0] != '0)
		|=> $stable(count[0]) && pre_count[0] + 1'b1 == $past(pre_count[0]))
		else $error("prescaler did not hold the counter");

	ext_idle_a: assert property ((ctrl.run[0] && ctrl.t1_ext && !pin_fall[2])
		|=> $stable(pre_count[0]) && $stable(count[0]))
		else $error("timer one moved without an event edge");

	// a zero latch keeps the counter at zero, so the step is checked by value
	cascade_step_a: assert property ((ctrl.run[1] && ctrl.cascade && underflow[0]
		&& pre_count[1] == '0) |=> count[1] == (($past(count[1]) == '0) ? $past(reload[1])
		: $past(count[1]) - 1'b1))
		else $error("timer two missed a cascade step");

	t3_narrow_a: assert property (pre_count[2][PRE_W-1:PRE3_W] == '0)
		else $error("timer three prescaler too wide");

	baud_pulse_a: assert property ((ctrl.t3_baud && underflow[2]) |=> baud_tick)
		else $error("missing bit-rate pulse");

	auto_reload_a: assert property (underflow[0] |=> count[0] == $past(reload[0]))
		else $error("timer one did not reload");

	capture_latch_a: assert property (pin_fall[1] |=> capture == $past(count[0]))
		else $error("capture latch missed timer one");

	edge_only_a: assert property ($rose(status[1]) |-> $past(pin_fall[0]))
		else $error("level one set without falling edge");

	global_gate_a: assert property (!ctrl.gie |=> !irq.req)
		else $error("request with global enable off");

	level_one_wins_a: assert property (pending[1] |=> irq.req && irq.level == 3'h1)
		else $error("level one not served first");

	vector_pick_a: assert property (pending[1] |=> irq.vector == $past(vec[0]))
		else $error("wrong vector for level one");

	cascade_cov: cover property (ctrl.cascade && underflow[1]);
	capture_cov: cover property (pin_fall[1] && ctrl.run[0]);
	baud_cov: cover property (baud_tick);
	level_five_cov: cover property (irq.req && irq.level == 3'h5);

endmodule : ttc_top

// ==== test/ttc_src.sv ====
// behavioural model of the external event and interrupt sources
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module ttc_src #(
	parameter int LOW_CYC = 3
) (
	// clock
	input  wire logic       sys_clk,
	// one-cycle requests from the bench
	input  wire logic [5:0] fire,
	// lines toward the block
	output      logic [3:0] pin,
	output      logic       rx_ev,
	output      logic       tx_ev
);
	int low_left [4];

	// pin lines idle high on pull-ups and serial events idle low, so no edge is seen at start
	initial begin
		pin = 4'hf;
		rx_ev = 1'b0;
		tx_ev = 1'b0;
		low_left = '{0, 0, 0, 0};
	end

	////////////////////////////////////////////////////////////////////////////////
	// a pin request is one falling edge, a serial request a one-cycle high pulse; longer LOW_CYC models a slow source
	always @(posedge sys_clk) begin
		for (int i = 0; i < 4; i++) begin
			if (fire[i]) begin
				pin[i] <= 1'b0;
				low_left[i] <= LOW_CYC;
			end else if (low_left[i] > 1) begin
				low_left[i] <= low_left[i] - 1;
			end else begin
				pin[i] <= 1'b1;
				low_left[i] <= 0;
			end
		end
		rx_ev <= fire[4];
		tx_ev <= fire[5];
	end
endmodule : ttc_src

// ==== test/tb_top.sv ====
// self-checking bench for the triple timer, capture and interrupt block
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module tb_top;
	import ttc_pkg::*;
	typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] e;} ttc_row_type;

	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic        hsel = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        baud_tick;
	ttc_irq_type irq;
	logic [5:0]  fire = 6'h0;
	logic [3:0]  pin;
	logic        rx_ev;
	logic        tx_ev;
	int          errors = 0;
	int          check_count = 0;
	int          ticks;

	ttc_row_type rows [11] = '{
		'{OFS_CTRL, 32'h1c0, 32'hc0},
		'{OFS_RELOAD, 32'hffff1234, 32'h1234},
		'{OFS_RELOAD + 12'h008, 32'h1f34, 32'h334},
		'{OFS_COUNT, 32'haa, 32'h1234},
		'{OFS_COUNT + 12'h008, 32'h0, 32'h334},
		'{OFS_CAPTURE, 32'hff, 32'h0},
		'{OFS_STATUS, 32'h3e, 32'h0},
		'{OFS_CLEAR, 32'h3e, 32'h0},
		'{OFS_ENABLE, 32'hff, 32'h3e},
		'{OFS_VECTOR, 32'hdeadbeef, 32'hbeef},
		'{12'h044, 32'h1, 32'h0}
	};

	ttc_top dut (.sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_irq_high_pin(pin[0]),
		.ext_irq_capture_pin(pin[1]), .event_count_in_one(pin[2]),
		.event_count_in_two(pin[3]), .serial_rx_event(rx_ev), .serial_tx_event(tx_ev),
		.irq(irq), .baud_tick(baud_tick));
	ttc_src src (.sys_clk(sys_clk), .fire(fire), .pin(pin), .rx_ev(rx_ev), .tx_ev(tx_ev));

	initial begin
		forever #5 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// entered just after a rising edge; hready is read before that edge's updates land
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] r);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h0, a};
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : bus

	// the pause lets status and irq follow the write before anyone looks
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
		repeat (2) @(posedge sys_clk);
	endtask : wr

	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask : rc

	task automatic ev(input int b);
		fire[b] <= 1'b1;
		@(posedge sys_clk);
		fire <= 6'h0;
		repeat (8) @(posedge sys_clk);
	endtask : ev

	task automatic tally_and_finish();
		if (errors == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish

	// the whole run needs some 2500 cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		errors++;
		tally_and_finish();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rc(rows[i].a, rows[i].e);
		end
		// reset in mid-run
		reset <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk(32'({irq, hreadyout, hresp, baud_tick}), 32'({20'h0, 3'b100}));
		reset <= 1'b0;
		@(posedge sys_clk);
		rc(OFS_RELOAD, 32'hff);
		rc(OFS_CTRL, 32'h0);
		rc(OFS_ENABLE, 32'h0);
		// priority, vectors, masking and capture
		for (int l = 1; l <= 5; l++) begin
			wr(OFS_VECTOR + 12'(4 * (l - 1)), 32'(l * 32'h1111));
		end
		wr(OFS_RELOAD, 32'h57);
		wr(OFS_ENABLE, 32'h3e);
		wr(OFS_CTRL, 32'h80);
		ev(1);
		chk(32'(irq), 32'({1'b1, 3'd3, 16'h3333}));
		rc(OFS_CAPTURE, 32'h57);
		ev(0);
		chk(32'(irq), 32'({1'b1, 3'd1, 16'h1111}));
		rc(OFS_STATUS, 32'ha);
		wr(OFS_CLEAR, 32'h2);
		chk(32'(irq), 32'({1'b1, 3'd3, 16'h3333}));
		ev(4);
		wr(OFS_ENABLE, 32'h36);
		chk(32'(irq), 32'({1'b1, 3'd4, 16'h4444}));
		wr(OFS_CTRL, 32'h0);
		chk(32'(irq.req), 32'h0);
		wr(OFS_CLEAR, 32'h3e);
		ev(5);
		rc(OFS_STATUS, 32'h10);
		// timer one on the state clock: prescale 1, reload 2, underflow on the sixth tick
		wr(OFS_CLEAR, 32'h3e);
		wr(OFS_RELOAD, 32'h102);
		wr(OFS_CTRL, 32'h1);
		repeat (150) @(posedge sys_clk);
		rc(OFS_STATUS, 32'h0);
		repeat (100) @(posedge sys_clk);
		rc(OFS_STATUS, 32'h4);
		// external clocking of timers one and two
		wr(OFS_CTRL, 32'h0);
		wr(OFS_CLEAR, 32'h3e);
		wr(OFS_RELOAD, 32'h1);
		wr(OFS_RELOAD + 12'h004, 32'h0);
		wr(OFS_CTRL, 32'h1b);
		ev(2);
		rc(OFS_STATUS, 32'h0);
		ev(2);
		rc(OFS_STATUS, 32'h4);
		ev(3);
		rc(OFS_STATUS, 32'h24);
		// capture while timer one runs: it has stepped 1, 0, reload 1
		ev(1);
		rc(OFS_CAPTURE, 32'h1);
		// cascade: timer two steps only on timer one underflow
		wr(OFS_CTRL, 32'h0);
		wr(OFS_CLEAR, 32'h3e);
		wr(OFS_RELOAD, 32'h0);
		wr(OFS_RELOAD + 12'h004, 32'h1);
		wr(OFS_CTRL, 32'h2b);
		ev(2);
		rc(OFS_STATUS, 32'h4);
		ev(2);
		rc(OFS_STATUS, 32'h24);
		// timer three as bit-rate clock: divide (3+1)*(0+1) states
		wr(OFS_CTRL, 32'h0);
		wr(OFS_CLEAR, 32'h3e);
		wr(OFS_RELOAD + 12'h008, 32'h300);
		wr(OFS_CTRL, 32'h44);
		ticks = 0;
		repeat (1600) begin
			@(posedge sys_clk);
			if (baud_tick === 1'b1) ticks++;
		end
		chk(32'(ticks), 32'd10);
		rc(OFS_STATUS, 32'h0);
		wr(OFS_CTRL, 32'h4);
		repeat (200) @(posedge sys_clk);
		rc(OFS_STATUS, 32'h10);
		tally_and_finish();
	end
endmodule : tb_top
